/* pkg/psa_pkg.sv */
package psa_pkg;

  localparam int EA_W = 16;
  localparam int PA_W = 24;
  localparam int PAGE_W = 8;
  localparam int FILE_ADDR_W = 13;
  localparam int LIT5_W = 5;
  localparam int LIT14_W = 14;
  localparam int LIT16_W = 16;
  localparam int BASE_FIELD_W = 4;

  localparam logic [11:0] OFF_TABLE_PAGE = 12'h000;
  localparam logic [11:0] OFF_VIS_PAGE = 12'h004;
  localparam logic [11:0] OFF_CORE_CONTROL = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;

  localparam logic [7:0] RST_TABLE_PAGE = 8'h00;
  localparam logic [7:0] RST_VIS_PAGE = 8'h00;
  localparam logic RST_VIS_ENABLE = 1'b0;

  localparam int CC_VIS_ENABLE_BIT = 2;
  localparam int TPAGE_CONFIG_BIT = 7;
  localparam int EA_WINDOW_BIT = 15;
  localparam int ST_LAST_VIS_BIT = 24;
  localparam int ST_BUSY_BIT = 25;

  localparam logic [2:0] KIND_DATA_RD = 3'h0;
  localparam logic [2:0] KIND_TBL_RD_LO = 3'h1;
  localparam logic [2:0] KIND_TBL_RD_HI = 3'h2;
  localparam logic [2:0] KIND_TBL_WR_LO = 3'h3;
  localparam logic [2:0] KIND_TBL_WR_HI = 3'h4;

  localparam logic [2:0] MODE_FILE_DIRECT = 3'h0;
  localparam logic [2:0] MODE_INDIRECT = 3'h1;
  localparam logic [2:0] MODE_POST_INC = 3'h2;
  localparam logic [2:0] MODE_POST_DEC = 3'h3;
  localparam logic [2:0] MODE_PRE_INC = 3'h4;
  localparam logic [2:0] MODE_PRE_DEC = 3'h5;
  localparam logic [2:0] MODE_REG_OFFSET = 3'h6;
  localparam logic [2:0] MODE_LIT_OFFSET = 3'h7;

  localparam logic [1:0] OP2_WORKING = 2'h0;
  localparam logic [1:0] OP2_MEMORY = 2'h1;
  localparam logic [1:0] OP2_LIT5 = 2'h2;

  localparam logic [1:0] LIT_KIND_5 = 2'h0;
  localparam logic [1:0] LIT_KIND_14 = 2'h1;
  localparam logic [1:0] LIT_KIND_16S = 2'h2;

  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] STEP_BYTE = 16'h0001;

  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_MOVE = 2'h1;
  localparam logic [1:0] EXTRA_OTHER = 2'h2;
  localparam logic [1:0] EXTRA_REPEAT_EDGE = 2'h2;

  localparam logic [3:0] DEFAULT_DEFAULT_WORKING_REG_INDEX = 4'h0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACCESS = 4'b0010,
    ST_LATCH = 4'b0100,
    ST_EXTRA = 4'b1000
  } psa_state_e;

endpackage

/* logic/psa_unit.sv */
`timescale 1ns/1ps
// Function
// - table address is page above effective address
// - page bit 7 selects configuration memory
// - redirect when address bit 15 and enable
// - visibility address is page plus 15 bits
// - visibility page bit 0 becomes address bit 15
// - visibility never reaches configuration space
// - program words step by two addresses
// - low word read returns bits 15 to 0
// - low byte read selects byte by select bit
// - high word read zero-extends bits 23 to 16
// - high phantom byte reads as zero
// - window is upper half from 8000h
// - visibility read returns low 16 bits only
// - visibility suspended during table accesses
// - outside repeat, move one, others two extra
// - repeat edges two extra, else none
// - 13-bit file address, working zero default
// - first operand direct base, second selectable
// - pointer post-modified or pre-modified
// - indexed address is pointer plus base
// - branch 16-bit signed, disable 14-bit literal
module psa_unit
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire logic [2:0] req_kind,
  input wire logic [2:0] req_mode,
  input wire logic req_byte_mode,
  input wire logic [15:0] req_pointer,
  input wire logic [15:0] req_base,
  input wire logic [3:0] req_base_field,
  input wire logic [3:0] req_reg_field,
  input wire logic req_use_default_default_working_reg,
  input wire logic [12:0] req_file_addr,
  input wire logic [15:0] req_literal,
  input wire logic [1:0] req_lit_kind,
  input wire logic [1:0] req_op2_sel,
  input wire logic [15:0] req_wdata,
  input wire logic req_move_class,
  input wire logic req_in_repeat,
  input wire logic req_rpt_first,
  input wire logic req_rpt_last,
  input wire logic req_rpt_irq_exit,
  input wire logic req_rpt_reentry,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [15:0] rsp_ea,
  output logic [15:0] op1_value,
  output logic [15:0] op2_value,
  output logic [23:0] lit_value,
  output logic [3:0] reg_index,
  output logic [3:0] base_index,
  output logic ptr_wb_valid,
  output logic [15:0] ptr_wb_value,
  output logic pm_rd_en,
  output logic pm_wr_en,
  output logic [23:0] pm_addr,
  output logic [23:0] pm_wdata,
  output logic [2:0] pm_wr_be,
  input wire logic [23:0] pm_rdata,
  output logic dm_rd_en,
  output logic [15:0] dm_addr,
  input wire logic [15:0] dm_rdata
);

  logic [7:0] tpage_reg;
  logic [7:0] vpage_reg;
  logic vis_en_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  psa_pkg::psa_state_e state_reg;
  psa_pkg::psa_state_e state_next;

  logic [2:0] kind_reg;
  logic byte_mode_reg;
  logic bsel_reg;
  logic prog_reg;
  logic [1:0] op2_sel_reg;
  logic [1:0] extra_reg;
  logic [15:0] hold_reg;
  logic last_vis_reg;
  logic [15:0] pointer_reg;

  logic req_ready_reg;
  logic rsp_valid_reg;
  logic [15:0] rsp_data_reg;
  logic [15:0] rsp_ea_reg;
  logic [15:0] op1_value_reg;
  logic [15:0] op2_value_reg;
  logic [23:0] lit_value_reg;
  logic [3:0] reg_index_reg;
  logic [3:0] base_index_reg;
  logic ptr_wb_valid_reg;
  logic [15:0] ptr_wb_value_reg;
  logic pm_rd_en_reg;
  logic pm_wr_en_reg;
  logic [23:0] pm_addr_reg;
  logic [23:0] pm_wdata_reg;
  logic [2:0] pm_wr_be_reg;
  logic dm_rd_en_reg;
  logic [15:0] dm_addr_reg;

  // register bus decode; one wait state lets read data come from a flop
  wire apb_access = psel & penable;
  wire apb_first = apb_access & ~pready_reg;
  wire apb_done = apb_access & pready_reg;
  wire hit_tpage = (paddr == psa_pkg::OFF_TABLE_PAGE);
  wire hit_vpage = (paddr == psa_pkg::OFF_VIS_PAGE);
  wire hit_cc = (paddr == psa_pkg::OFF_CORE_CONTROL);
  wire hit_status = (paddr == psa_pkg::OFF_STATUS);
  wire apb_mapped = hit_tpage | hit_vpage | hit_cc | hit_status;
  wire apb_wr = apb_done & pwrite & ~pslverr_reg;
  wire busy = (state_reg != psa_pkg::ST_IDLE);

  wire [31:0] status_word = {6'h00, busy, last_vis_reg, pm_addr_reg};
  wire [31:0] cc_word = {29'h0000_0000, vis_en_reg, 2'h0};
  wire [31:0] rd_mux = hit_tpage ? {24'h00_0000, tpage_reg} :
                       hit_vpage ? {24'h00_0000, vpage_reg} :
                       hit_cc ? cc_word :
                       hit_status ? status_word : 32'h0000_0000;

  // effective address forming
  wire is_table = (req_kind == psa_pkg::KIND_TBL_RD_LO) | (req_kind == psa_pkg::KIND_TBL_RD_HI) |
                  (req_kind == psa_pkg::KIND_TBL_WR_LO) | (req_kind == psa_pkg::KIND_TBL_WR_HI);
  wire is_table_wr = (req_kind == psa_pkg::KIND_TBL_WR_LO) |
                     (req_kind == psa_pkg::KIND_TBL_WR_HI);
  wire [15:0] step = req_byte_mode ? psa_pkg::STEP_BYTE : psa_pkg::STEP_WORD;
  wire [15:0] ptr_inc = req_pointer + step;
  wire [15:0] ptr_dec = req_pointer - step;
  wire [15:0] file_ea = {3'h0, req_file_addr};
  wire [15:0] index_ea = req_pointer + req_base;
  wire [15:0] litoff_ea = req_pointer + req_literal;
  wire mode_pre = (req_mode == psa_pkg::MODE_PRE_INC) | (req_mode == psa_pkg::MODE_PRE_DEC);
  wire mode_post = (req_mode == psa_pkg::MODE_POST_INC) | (req_mode == psa_pkg::MODE_POST_DEC);
  wire mode_inc = (req_mode == psa_pkg::MODE_POST_INC) | (req_mode == psa_pkg::MODE_PRE_INC);
  wire [15:0] ptr_mod = mode_inc ? ptr_inc : ptr_dec;
  wire [15:0] ea = (req_mode == psa_pkg::MODE_FILE_DIRECT) ? file_ea :
                   (req_mode == psa_pkg::MODE_REG_OFFSET) ? index_ea :
                   (req_mode == psa_pkg::MODE_LIT_OFFSET) ? litoff_ea :
                   mode_pre ? ptr_mod : req_pointer;

  // only a data-read kind can be redirected, so a table access always
  // goes by the table page and never through the visibility window
  wire in_window = ea[psa_pkg::EA_WINDOW_BIT];
  wire vis_hit = ~is_table & in_window & vis_en_reg;

  // program addresses clear bit 0; the byte lane goes by ea[0]; word index is bits 23:1
  wire [23:0] table_pa = {tpage_reg, ea[15:1], 1'b0};
  wire [23:0] vis_pa = {1'b0, vpage_reg, ea[14:1], 1'b0};
  wire [23:0] req_pa = is_table ? table_pa : vis_pa;

  wire [2:0] wr_be_lo = req_byte_mode ? {1'b0, ea[0], ~ea[0]} : 3'b011;
  wire [2:0] wr_be_hi = (req_byte_mode & ea[0]) ? 3'b000 : 3'b100;
  wire [2:0] wr_be = (req_kind == psa_pkg::KIND_TBL_WR_HI) ? wr_be_hi : wr_be_lo;
  wire [7:0] wr_byte = (req_byte_mode & ea[0]) ? req_wdata[7:0] : req_wdata[7:0];
  wire [23:0] wr_word = (req_kind == psa_pkg::KIND_TBL_WR_HI) ? {wr_byte, 16'h0000} :
                        req_byte_mode ? {8'h00, req_wdata[7:0], req_wdata[7:0]} :
                        {8'h00, req_wdata};

  wire rpt_edge = req_rpt_first | req_rpt_last | req_rpt_irq_exit | req_rpt_reentry;
  wire [1:0] extra_rpt = rpt_edge ? psa_pkg::EXTRA_REPEAT_EDGE : psa_pkg::EXTRA_NONE;
  wire [1:0] extra_plain = req_move_class ? psa_pkg::EXTRA_MOVE : psa_pkg::EXTRA_OTHER;
  wire [1:0] extra = ~vis_hit ? psa_pkg::EXTRA_NONE :
                     req_in_repeat ? extra_rpt : extra_plain;

  wire [23:0] lit5 = {19'h0_0000, req_literal[4:0]};
  wire [23:0] lit14 = {10'h000, req_literal[13:0]};
  wire [23:0] lit16 = {{8{req_literal[15]}}, req_literal};
  wire [23:0] lit_sel = (req_lit_kind == psa_pkg::LIT_KIND_14) ? lit14 :
                        (req_lit_kind == psa_pkg::LIT_KIND_16S) ? lit16 : lit5;

  // read data formatting, from the captured request shape
  wire [15:0] pm_low = pm_rdata[15:0];
  wire [7:0] pm_high = pm_rdata[23:16];
  wire [15:0] fmt_lo_byte = {8'h00, bsel_reg ? pm_low[15:8] : pm_low[7:0]};
  wire [15:0] fmt_lo = byte_mode_reg ? fmt_lo_byte : pm_low;
  wire [15:0] fmt_hi_byte = bsel_reg ? 16'h0000 : {8'h00, pm_high};
  wire [15:0] fmt_hi = byte_mode_reg ? fmt_hi_byte : {8'h00, pm_high};
  wire [15:0] fmt_prog = (kind_reg == psa_pkg::KIND_TBL_RD_HI) ? fmt_hi :
                         (kind_reg == psa_pkg::KIND_TBL_RD_LO) ? fmt_lo : pm_low;
  wire wr_kind_reg = (kind_reg == psa_pkg::KIND_TBL_WR_LO) |
                     (kind_reg == psa_pkg::KIND_TBL_WR_HI);
  wire [15:0] rd_value = wr_kind_reg ? 16'h0000 : prog_reg ? fmt_prog : dm_rdata;
  wire [15:0] rsp_value = (state_reg == psa_pkg::ST_LATCH) ? rd_value : hold_reg;
  wire [15:0] op2_mux = (op2_sel_reg == psa_pkg::OP2_MEMORY) ? rsp_value :
                        (op2_sel_reg == psa_pkg::OP2_LIT5) ? lit_value_reg[15:0] :
                        pointer_reg;

  wire accept = req_ready_reg & req_valid;
  wire finish = state_next == psa_pkg::ST_IDLE && busy;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      psa_pkg::ST_IDLE:
      begin
        if (accept)
          state_next = psa_pkg::ST_ACCESS;
      end
      psa_pkg::ST_ACCESS:
        state_next = psa_pkg::ST_LATCH;
      psa_pkg::ST_LATCH:
      begin
        if (extra_reg != psa_pkg::EXTRA_NONE)
          state_next = psa_pkg::ST_EXTRA;
        else
          state_next = psa_pkg::ST_IDLE;
      end
      psa_pkg::ST_EXTRA:
      begin
        if (extra_reg == psa_pkg::EXTRA_MOVE)
          state_next = psa_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tpage_reg <= psa_pkg::RST_TABLE_PAGE;
      vpage_reg <= psa_pkg::RST_VIS_PAGE;
      vis_en_reg <= psa_pkg::RST_VIS_ENABLE;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= apb_first;
      if (apb_first)
      begin
        pslverr_reg <= ~apb_mapped;
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      end
      if (apb_wr & hit_tpage)
        tpage_reg <= pwdata[7:0];
      if (apb_wr & hit_vpage)
        vpage_reg <= pwdata[7:0];
      if (apb_wr & hit_cc)
        vis_en_reg <= pwdata[psa_pkg::CC_VIS_ENABLE_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= psa_pkg::ST_IDLE;
      kind_reg <= psa_pkg::KIND_DATA_RD;
      byte_mode_reg <= 1'b0;
      bsel_reg <= 1'b0;
      prog_reg <= 1'b0;
      op2_sel_reg <= psa_pkg::OP2_WORKING;
      extra_reg <= psa_pkg::EXTRA_NONE;
      hold_reg <= 16'h0000;
      last_vis_reg <= 1'b0;
      pointer_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      if (accept)
      begin
        kind_reg <= req_kind;
        byte_mode_reg <= req_byte_mode;
        bsel_reg <= ea[0];
        prog_reg <= is_table | vis_hit;
        op2_sel_reg <= req_op2_sel;
        extra_reg <= extra;
        pointer_reg <= req_pointer;
        last_vis_reg <= vis_hit;
      end
      else if (state_reg == psa_pkg::ST_EXTRA)
        extra_reg <= extra_reg - 2'h1;
      if (state_reg == psa_pkg::ST_LATCH)
        hold_reg <= rd_value;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      req_ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 16'h0000;
      rsp_ea_reg <= 16'h0000;
      op1_value_reg <= 16'h0000;
      op2_value_reg <= 16'h0000;
      lit_value_reg <= 24'h00_0000;
      reg_index_reg <= psa_pkg::DEFAULT_DEFAULT_WORKING_REG_INDEX;
      base_index_reg <= 4'h0;
      ptr_wb_valid_reg <= 1'b0;
      ptr_wb_value_reg <= 16'h0000;
    end
    else
    begin
      req_ready_reg <= (state_next == psa_pkg::ST_IDLE);
      rsp_valid_reg <= finish;
      ptr_wb_valid_reg <= accept & (mode_pre | mode_post);
      if (accept)
      begin
        rsp_ea_reg <= ea;
        op1_value_reg <= req_base;
        lit_value_reg <= lit_sel;
        reg_index_reg <= req_use_default_default_working_reg ? psa_pkg::DEFAULT_DEFAULT_WORKING_REG_INDEX :
                         req_reg_field;
        base_index_reg <= req_base_field;
        ptr_wb_value_reg <= ptr_mod;
      end
      if (finish)
      begin
        rsp_data_reg <= rsp_value;
        op2_value_reg <= op2_mux;
      end
    end
  end

  // memory strobes stand for the one ACCESS cycle only
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pm_rd_en_reg <= 1'b0;
      pm_wr_en_reg <= 1'b0;
      pm_addr_reg <= 24'h00_0000;
      pm_wdata_reg <= 24'h00_0000;
      pm_wr_be_reg <= 3'h0;
      dm_rd_en_reg <= 1'b0;
      dm_addr_reg <= 16'h0000;
    end
    else
    begin
      pm_rd_en_reg <= accept & ((is_table & ~is_table_wr) | vis_hit);
      pm_wr_en_reg <= accept & is_table_wr;
      dm_rd_en_reg <= accept & ~is_table & ~vis_hit;
      if (accept & (is_table | vis_hit))
      begin
        pm_addr_reg <= req_pa;
        pm_wdata_reg <= wr_word;
        pm_wr_be_reg <= is_table_wr ? wr_be : 3'h0;
      end
      if (accept & ~is_table & ~vis_hit)
        dm_addr_reg <= ea;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign req_ready = req_ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign rsp_ea = rsp_ea_reg;
  assign op1_value = op1_value_reg;
  assign op2_value = op2_value_reg;
  assign lit_value = lit_value_reg;
  assign reg_index = reg_index_reg;
  assign base_index = base_index_reg;
  assign ptr_wb_valid = ptr_wb_valid_reg;
  assign ptr_wb_value = ptr_wb_value_reg;
  assign pm_rd_en = pm_rd_en_reg;
  assign pm_wr_en = pm_wr_en_reg;
  assign pm_addr = pm_addr_reg;
  assign pm_wdata = pm_wdata_reg;
  assign pm_wr_be = pm_wr_be_reg;
  assign dm_rd_en = dm_rd_en_reg;
  assign dm_addr = dm_addr_reg;

endmodule // psa_unit

/* test/psa_mem_model.sv */
`timescale 1ns/1ps
// one-cycle synchronous memories; between reads the data lines toggle so stale data is caught
module psa_mem_model
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pm_rd_en,
  input wire logic [23:0] pm_addr,
  output logic [23:0] pm_rdata,
  input wire logic dm_rd_en,
  input wire logic [15:0] dm_addr,
  output logic [15:0] dm_rdata
);
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      pm_rdata <= 24'h00_0000;
      dm_rdata <= 16'h0000;
    end
    else
    begin
      pm_rdata <= pm_rd_en ? {pm_addr[7:0] ^ 8'h5a, pm_addr[15:0] ^ 16'hc3c3} : ~pm_rdata;
      dm_rdata <= dm_rd_en ? dm_addr ^ 16'ha5a5 : ~dm_rdata;
    end
endmodule // psa_mem_model

/* test/psa_checker.sv */
`timescale 1ns/1ps
module psa_checker
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [2:0] req_kind,
  input wire logic [2:0] req_mode,
  input wire logic req_byte_mode,
  input wire logic [15:0] req_pointer,
  input wire logic [15:0] req_base,
  input wire logic req_move_class,
  input wire logic req_in_repeat,
  input wire logic req_rpt_first,
  input wire logic req_rpt_last,
  input wire logic req_rpt_irq_exit,
  input wire logic req_rpt_reentry,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic [15:0] rsp_ea,
  input wire logic ptr_wb_valid,
  input wire logic [15:0] ptr_wb_value,
  input wire logic pm_rd_en,
  input wire logic [23:0] pm_addr,
  input wire logic [23:0] pm_rdata,
  input wire logic dm_rd_en
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [2:0] kind_reg;
  logic byte_reg, move_reg, rpt_reg, edge_reg, vis_reg, pmd_reg;
  logic [3:0] cnt_reg;
  logic [23:0] cap_reg;
  wire acc = req_valid && req_ready;
  wire tbl = kind_reg >= psa_pkg::KIND_TBL_RD_LO && kind_reg <= psa_pkg::KIND_TBL_WR_HI;
  wire [3:0] extra = !vis_reg ? 4'h0 : rpt_reg ? {2'h0, edge_reg, 1'b0} : {2'h0, !move_reg, move_reg};
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      {kind_reg, byte_reg, move_reg, rpt_reg, edge_reg, vis_reg, pmd_reg} <= '0;
      cnt_reg <= 4'h0;
      cap_reg <= 24'h00_0000;
    end
    else
    begin
      pmd_reg <= pm_rd_en;
      cnt_reg <= acc ? 4'h0 : cnt_reg + 4'h1;
      if (pmd_reg)
        cap_reg <= pm_rdata;
      if (acc)
      begin
        {kind_reg, byte_reg, move_reg, rpt_reg} <= {req_kind, req_byte_mode, req_move_class, req_in_repeat};
        edge_reg <= req_rpt_first | req_rpt_last | req_rpt_irq_exit | req_rpt_reentry;
        vis_reg <= 1'b0;
      end
      else if (pm_rd_en && !tbl)
        vis_reg <= 1'b1;
    end
  property p_tbl_addr;
    pm_rd_en && tbl |-> pm_addr[15:0] == (rsp_ea & 16'hfffe);
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");
  property p_vis_addr;
    pm_rd_en && !tbl |-> rsp_ea[15] && !pm_addr[23] && pm_addr[14:0] == (rsp_ea[14:0] & 15'h7ffe);
  endproperty
  a_vis_addr: assert property (p_vis_addr) else $error("window address wrong");
  property p_tbl_path;
    acc && (req_kind == psa_pkg::KIND_TBL_RD_LO || req_kind == psa_pkg::KIND_TBL_RD_HI) |=> pm_rd_en && !dm_rd_en;
  endproperty
  a_tbl_path: assert property (p_tbl_path) else $error("table read misrouted");
  property p_rd_low;
    rsp_valid && (vis_reg || (kind_reg == psa_pkg::KIND_TBL_RD_LO && !byte_reg)) |-> rsp_data == cap_reg[15:0];
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("low word data wrong");
  property p_rd_high;
    rsp_valid && kind_reg == psa_pkg::KIND_TBL_RD_HI |-> rsp_data[15:8] == 8'h00 && rsp_data[7:0] == ((byte_reg && rsp_ea[0]) ? 8'h00 : cap_reg[23:16]);
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("high byte data wrong");
  property p_latency;
    rsp_valid |-> cnt_reg == 4'h2 + extra;
  endproperty
  a_latency: assert property (p_latency) else $error("response latency wrong");
  property p_plain;
    dm_rd_en |-> ##2 rsp_valid;
  endproperty
  a_plain: assert property (p_plain) else $error("plain read delayed");
  property p_post_mod;
    acc && req_mode == psa_pkg::MODE_POST_INC && !req_byte_mode |=> ptr_wb_valid && ptr_wb_value == $past(req_pointer) + psa_pkg::STEP_WORD && rsp_ea == $past(req_pointer);
  endproperty
  a_post_mod: assert property (p_post_mod) else $error("post increment wrong");
  property p_indexed;
    acc && req_mode == psa_pkg::MODE_REG_OFFSET |=> rsp_ea == $past(req_pointer) + $past(req_base);
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");
  cover property (rsp_valid && vis_reg);
  cover property (rsp_valid && kind_reg == psa_pkg::KIND_TBL_RD_HI);
  cover property (ptr_wb_valid);
endmodule // psa_checker
bind psa_unit psa_checker u_chk (.*);

/* test/program_space_access_unit_test.sv */
`timescale 1ns/1ps
module program_space_access_unit_test;
  typedef struct packed {
    logic [2:0] kind;
    logic bm;
    logic ven;
    logic [7:0] tp;
    logic [7:0] vp;
    logic [15:0] ea;
    logic [23:0] pa;
    logic [2:0] be;
  } psa_row_s;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic req_valid, req_byte_mode, req_use_default_default_working_reg, req_move_class, req_in_repeat;
  logic req_rpt_first, req_rpt_last, req_rpt_irq_exit, req_rpt_reentry, req_ready, rsp_valid;
  logic [2:0] req_kind, req_mode, pm_wr_be, g_be;
  logic [15:0] req_pointer, req_base, req_literal, req_wdata, rsp_data, rsp_ea, op1_value;
  logic [15:0] op2_value, ptr_wb_value, dm_addr, dm_rdata, g_wbv, g_ea, exp16;
  logic [3:0] req_base_field, req_reg_field, reg_index, base_index, g_ri;
  logic [12:0] req_file_addr;
  logic [1:0] req_lit_kind, req_op2_sel;
  logic [23:0] lit_value, pm_addr, pm_wdata, pm_rdata, g_pa, g_lit, w;
  logic ptr_wb_valid, pm_rd_en, pm_wr_en, dm_rd_en, g_pm, g_dm, g_wb;
  int errors, compares, lat, i;
  psa_row_s rows [13];
  psa_unit dut (.*);
  psa_mem_model u_mem (.*);
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [23:0] pm_word(input logic [23:0] a);
    return {a[7:0] ^ 8'h5a, a[15:0] ^ 16'hc3c3};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic cpu(input logic [2:0] k, input logic [2:0] m, input logic bm, input logic [15:0] p);
    @(posedge core_clk);
    while (req_ready !== 1'b1)
      @(posedge core_clk);
    {req_valid, req_kind, req_mode, req_byte_mode, req_pointer} <= {1'b1, k, m, bm, p};
    @(posedge core_clk);
    req_valid <= 1'b0;
    {g_pm, g_dm} = 2'b00;
    for (lat = 1; lat < 16; lat++)
    begin
      @(posedge core_clk);
      if (lat == 1)
        {g_ea, g_wb, g_wbv, g_ri, g_lit} = {rsp_ea, ptr_wb_valid, ptr_wb_value, reg_index, lit_value};
      if (pm_rd_en || pm_wr_en)
        {g_pm, g_pa, g_be} = {1'b1, pm_addr, pm_wr_be};
      g_dm = g_dm | dm_rd_en;
      if (rsp_valid === 1'b1)
        break;
    end
  endtask
  initial
  begin
    #20000;
    errors++;
    test_done;
  end
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata, req_valid, req_kind, req_mode} = '0;
    {req_byte_mode, req_use_default_default_working_reg, req_move_class, req_in_repeat, req_pointer} = '0;
    {req_rpt_first, req_rpt_last, req_rpt_irq_exit, req_rpt_reentry, req_base, req_literal} = '0;
    {req_base_field, req_reg_field, req_file_addr, req_lit_kind, req_op2_sel} = '0;
    req_wdata = 16'hbeef;
    req_file_addr = 13'h1abc;
    rst = 1'b1;
    rows[0] = '{3'h1, 1'b0, 1'b0, 8'h12, 8'h00, 16'h3456, 24'h12_3456, 3'h0};
    rows[1] = '{3'h1, 1'b1, 1'b0, 8'h12, 8'h00, 16'h3457, 24'h12_3456, 3'h0};
    rows[2] = '{3'h1, 1'b1, 1'b0, 8'h80, 8'h00, 16'h3456, 24'h80_3456, 3'h0};
    rows[3] = '{3'h2, 1'b0, 1'b0, 8'h7f, 8'h00, 16'hfffe, 24'h7f_fffe, 3'h0};
    rows[4] = '{3'h2, 1'b1, 1'b0, 8'h01, 8'h00, 16'h0001, 24'h01_0000, 3'h0};
    rows[5] = '{3'h2, 1'b1, 1'b0, 8'h01, 8'h00, 16'h0000, 24'h01_0000, 3'h0};
    rows[6] = '{3'h0, 1'b0, 1'b1, 8'h00, 8'h81, 16'h8002, 24'h40_8002, 3'h0};
    rows[7] = '{3'h0, 1'b0, 1'b1, 8'h00, 8'hfe, 16'hfffe, 24'h7f_7ffe, 3'h0};
    rows[8] = '{3'h0, 1'b0, 1'b0, 8'h00, 8'h81, 16'h8000, 24'hff_ffff, 3'h0};
    rows[9] = '{3'h0, 1'b0, 1'b1, 8'h00, 8'h81, 16'h7ffe, 24'hff_ffff, 3'h0};
    rows[10] = '{3'h1, 1'b0, 1'b1, 8'h03, 8'h55, 16'h9000, 24'h03_9000, 3'h0};
    rows[11] = '{3'h3, 1'b1, 1'b1, 8'h04, 8'h55, 16'h8001, 24'h04_8000, 3'h2};
    rows[12] = '{3'h4, 1'b0, 1'b0, 8'h04, 8'h00, 16'h0102, 24'h04_0102, 3'h4};
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    // page, window page and control registers come out of reset cleared
    for (i = 0; i < 3; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(err, 1'b1);
    apb(1'b1, psa_pkg::OFF_CORE_CONTROL, 32'hffff_ffff);
    apb(1'b0, psa_pkg::OFF_CORE_CONTROL, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    for (i = 0; i < 13; i++)
    begin
      apb(1'b1, psa_pkg::OFF_TABLE_PAGE, {24'h00_0000, rows[i].tp});
      apb(1'b1, psa_pkg::OFF_VIS_PAGE, {24'h00_0000, rows[i].vp});
      apb(1'b1, psa_pkg::OFF_CORE_CONTROL, {29'h0000_0000, rows[i].ven, 2'h0});
      cpu(rows[i].kind, psa_pkg::MODE_INDIRECT, rows[i].bm, rows[i].ea);
      w = pm_word(rows[i].pa);
      case (rows[i].kind)
        3'h1: exp16 = !rows[i].bm ? w[15:0] : {8'h00, rows[i].ea[0] ? w[15:8] : w[7:0]};
        3'h2: exp16 = (rows[i].bm && rows[i].ea[0]) ? 16'h0000 : {8'h00, w[23:16]};
        3'h0: exp16 = rows[i].pa[23] ? rows[i].ea ^ 16'ha5a5 : w[15:0];
        default: exp16 = 16'h0000;
      endcase
      chk(rsp_data, exp16);
      chk(g_dm, rows[i].pa === 24'hff_ffff);
      if (!g_dm)
        chk(g_pa, rows[i].pa);
      if (rows[i].kind > 3'h2)
      begin
        chk(g_be, rows[i].be);
        chk(pm_wdata, rows[i].kind == 3'h4 ? 24'hef_0000 : 24'h00_efef);
      end
      chk(lat, (rows[i].kind == 3'h0 && !g_dm) ? 5 : 3);
    end
    apb(1'b1, psa_pkg::OFF_CORE_CONTROL, 32'h0000_0000);
    for (i = 0; i < 8; i++)
    begin
      req_base <= 16'(i);
      req_literal <= 16'h8040 + 16'(i);
      req_lit_kind <= 2'(i % 3);
      req_use_default_default_working_reg <= i[0];
      req_reg_field <= 4'(15 - i);
      req_base_field <= 4'(i);
      req_op2_sel <= 2'(i);
      cpu(psa_pkg::KIND_DATA_RD, 3'(i), 1'b0, 16'h1000);
      case (i)
        0: exp16 = 16'h1abc;
        4: exp16 = 16'h1002;
        5: exp16 = 16'h0ffe;
        6: exp16 = 16'h1006;
        7: exp16 = 16'h9047;
        default: exp16 = 16'h1000;
      endcase
      chk(g_ea, exp16);
      chk(dm_addr, exp16);
      chk(op1_value, i);
      chk(base_index, i);
      chk(op2_value, i[1:0] == 1 ? exp16 ^ 16'ha5a5 : i == 2 ? 16'h8042 :
          i == 6 ? 16'h0006 : 16'h1000);
      chk(g_wb, i >= 2 && i <= 5);
      if (i == 2 || i == 4)
        chk(g_wbv, 16'h1002);
      if (i == 3 || i == 5)
        chk(g_wbv, 16'h0ffe);
      chk(g_lit, i % 3 == 0 ? i : i % 3 == 1 ? 24'h00_0040 + i : 24'hff_8040 + i);
      chk(g_ri, i[0] ? psa_pkg::DEFAULT_DEFAULT_WORKING_REG_INDEX : 4'(15 - i));
    end
    // each repeat edge flag alone, a middle iteration, then a move outside a loop
    apb(1'b1, psa_pkg::OFF_CORE_CONTROL, 32'h0000_0004);
    for (i = 0; i < 6; i++)
    begin
      {req_rpt_reentry, req_rpt_irq_exit, req_rpt_last, req_rpt_first} <= 4'(1 << i);
      req_in_repeat <= i < 5;
      req_move_class <= i == 5;
      cpu(psa_pkg::KIND_DATA_RD, psa_pkg::MODE_INDIRECT, 1'b0, 16'h8000);
      chk(lat, i < 4 ? 5 : i == 4 ? 3 : 4);
    end
    // a mid-run reset must drop the window enable set above
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, psa_pkg::OFF_CORE_CONTROL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    cpu(psa_pkg::KIND_DATA_RD, psa_pkg::MODE_INDIRECT, 1'b0, 16'h8000);
    chk(g_dm, 1'b1);
    chk(lat, 3);
    test_done;
  end
endmodule // program_space_access_unit_test
